/* rtl/tci_terminal_front.sv */
// Purpose: three-wire run decode, up/down ramp and analog/pulse input scaling
// Assumes: pins are asynchronous; configuration inputs are quasi-static
// Notes:   curves four and five are not built; selecting them yields 0.0 %
`default_nettype none

module tci_terminal_front #(
  parameter int unsigned TICK_CYC = tci_pkg::TICK_CYCLES
) (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         digital_input_one_i,
  input  wire logic                         digital_input_two_i,
  input  wire logic                         digital_input_three_i,
  input  wire logic                         pulse_capable_input_i,
  input  wire logic                         updown_up_i,
  input  wire logic                         updown_down_i,
  input  wire logic [1:0]                   terminal_command_scheme_i,
  input  wire logic [1:0]                   frequency_reference_resolution_i,
  input  wire logic [15:0]                  updown_ramp_rate_i,
  input  wire logic [2:0][15:0]             analog_sample_i,
  input  wire logic [2:0]                   analog_is_current_i,
  input  wire tci_pkg::tci_curve_t [2:0]    analog_curve_i,
  input  wire tci_pkg::tci_curve_t          pulse_curve_i,
  input  wire logic [3:0][9:0]              filter_time_i,
  input  wire logic [2:0][3:0]              analog_curve_select_i,
  input  wire logic [2:0]                   below_min_handling_select_i,
  output var  tci_pkg::tci_run_t            run_cmd_o,
  output logic signed [31:0]                updown_offset_o,
  output logic [2:0][15:0]                  analog_setting_o,
  output logic [15:0]                       pulse_setting_o,
  output logic [15:0]                       pulse_freq_o
);
  import tci_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic signed [35:0] sext36(input logic signed [15:0] v);
    return {{20{v[15]}}, v};
  endfunction : sext36

  function automatic logic [15:0] curve_map(input logic [15:0] x,
                                            input tci_curve_t c,
                                            input logic zero_below);
    logic signed [35:0] num;
    logic signed [35:0] den;
    logic signed [35:0] v;
    num = $signed({20'h00000, 16'(x - c.min_in)}) * (sext36(c.max_set) - sext36(c.min_set));
    den = $signed({20'h00000, 16'(c.max_in - c.min_in)});
    v   = 36'sh000000000;
    if (x < c.min_in) begin
      v = zero_below ? 36'sh000000000 : sext36(c.min_set);
    end else if (x >= c.max_in) begin
      v = sext36(c.max_set);
    end else begin
      v = sext36(c.min_set) + num / den;
    end
    if (v > SET_LIMIT) begin
      v = SET_LIMIT;
    end else if (v < -SET_LIMIT) begin
      v = -SET_LIMIT;
    end
    return v[15:0];
  endfunction : curve_map

  // first-order step toward x, span of (time + 1) filter periods
  function automatic logic [15:0] filt_step(input logic [15:0] y,
                                            input logic [15:0] x,
                                            input logic [9:0] ft);
    logic signed [17:0] d;
    logic signed [17:0] n;
    logic signed [17:0] r;
    d = $signed({2'b00, x}) - $signed({2'b00, y});
    n = $signed({8'h00, ft}) + 18'sh00001;
    r = $signed({2'b00, y}) + d / n;
    return r[15:0];
  endfunction : filt_step

  // ==========================================================================
  // pin synchronisers
  logic [DI_COUNT-1:0] pins;
  logic [DI_COUNT-1:0] sync1_q;
  logic [DI_COUNT-1:0] sync2_q;
  logic [DI_COUNT-1:0] sync3_q;
  logic [DI_COUNT-1:0] din_q;
  logic [DI_COUNT-1:0] din_prev_q;
  logic [DI_COUNT-1:0] rise;

  // only the fourth input carries pulses
  assign pins = {updown_down_i, updown_up_i, pulse_capable_input_i,
                 digital_input_three_i, digital_input_two_i, digital_input_one_i};

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a level counts only once two stages agree
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      din_q      <= '0;
      din_prev_q <= '0;
    end else begin
      din_q      <= ((sync2_q ~^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & din_q);
      din_prev_q <= din_q;
    end
  end

  // held buttons give one edge only
  assign rise = din_q & ~din_prev_q;

  // ==========================================================================
  // three-wire run decode
  tci_run_state_t run_state_q;
  tci_run_state_t dir_level;

  assign dir_level = din_q[DI_TWO] ? RUN_REVERSE : RUN_FORWARD;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_state_q <= RUN_STOPPED;
    end else begin
      case (terminal_command_scheme_i)
        SCHEME_THREE_WIRE_1: begin
          if (!din_q[DI_THREE]) begin
            run_state_q <= RUN_STOPPED;
          end else if (rise[DI_TWO]) begin
            run_state_q <= RUN_REVERSE;
          end else if (rise[DI_ONE]) begin
            run_state_q <= RUN_FORWARD;
          end
        end
        SCHEME_THREE_WIRE_2: begin
          if (!din_q[DI_THREE]) begin
            run_state_q <= RUN_STOPPED;
          end else if (rise[DI_ONE] || run_state_q != RUN_STOPPED) begin
            run_state_q <= dir_level;
          end
        end
        default: begin
          run_state_q <= RUN_STOPPED;
        end
      endcase
    end
  end

  assign run_cmd_o.run     = (run_state_q != RUN_STOPPED);
  assign run_cmd_o.reverse = (run_state_q == RUN_REVERSE);

  // ==========================================================================
  // time base
  logic [31:0] ms_cnt_q;
  logic [3:0]  filt_cnt_q;
  logic        ms_tick;
  logic        filt_tick;

  assign ms_tick   = (ms_cnt_q == 32'(TICK_CYC - 1));
  assign filt_tick = ms_tick && (filt_cnt_q == 4'(FILT_PERIOD_MS - 1));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt_q   <= '0;
      filt_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
      if (filt_tick) begin
        filt_cnt_q <= 4'h0;
      end else if (ms_tick) begin
        filt_cnt_q <= filt_cnt_q + 4'h1;
      end
    end
  end

  // ==========================================================================
  // up/down frequency trim
  logic [15:0]        rate_min;
  logic [15:0]        rate_lim;
  logic [19:0]        rate_fine;
  logic signed [39:0] trim_uhz_q;

  // coarse steps are 0.01 Hz/s, fine and default steps 0.001 Hz/s
  always_comb begin
    rate_min = (frequency_reference_resolution_i == RES_FINE ||
                frequency_reference_resolution_i == RES_COARSE) ? RATE_MIN_STEP : RATE_MIN_DEFAULT;
    rate_lim = (updown_ramp_rate_i < rate_min) ? rate_min : updown_ramp_rate_i;
    rate_fine = (frequency_reference_resolution_i == RES_COARSE) ?
                20'(rate_lim * COARSE_TO_FINE) : {4'h0, rate_lim};
  end

  // per ms, a rate in mHz/s adds the same figure in uHz
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trim_uhz_q <= '0;
    end else if (ms_tick && din_q[DI_UP] && !din_q[DI_DOWN]) begin
      trim_uhz_q <= trim_uhz_q + $signed({20'h00000, rate_fine});
    end else if (ms_tick && din_q[DI_DOWN] && !din_q[DI_UP]) begin
      trim_uhz_q <= trim_uhz_q - $signed({20'h00000, rate_fine});
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      updown_offset_o <= '0;
    end else begin
      updown_offset_o <= 32'(trim_uhz_q / UHZ_PER_MHZ);
    end
  end

  // ==========================================================================
  // pulse frequency measurement over one filter period
  logic [15:0] edge_cnt_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_cnt_q   <= '0;
      pulse_freq_o <= '0;
    end else if (filt_tick) begin
      edge_cnt_q   <= {15'h0000, rise[DI_PULSE]};
      pulse_freq_o <= 16'(edge_cnt_q * PULSE_COUNT_SCALE);
    end else if (rise[DI_PULSE]) begin
      edge_cnt_q <= edge_cnt_q + 16'h0001;
    end
  end

  // ==========================================================================
  // filtering and curve mapping; index 3 is the pulse channel
  logic [3:0][15:0]  chan_in;
  tci_curve_t [3:0]  chan_curve;
  logic [3:0]        chan_zero_below;
  logic [3:0]        chan_curve_ok;
  logic [3:0][15:0]  chan_filt_q;
  logic [3:0][15:0]  chan_set_q;

  always_comb begin
    for (int ch = 0; ch < 3; ch++) begin
      chan_in[ch] = analog_is_current_i[ch] ? {1'b0, analog_sample_i[ch][15:1]}
                                            : analog_sample_i[ch];
      chan_zero_below[ch] = below_min_handling_select_i[ch];
      // curves four and five have no four-point table here
      chan_curve_ok[ch] = (analog_curve_select_i[ch] >= CURVE_FIRST) &&
                          (analog_curve_select_i[ch] <= CURVE_LAST_TWO_PT);
      chan_curve[ch] = chan_curve_ok[ch] ?
                       analog_curve_i[2'(analog_curve_select_i[ch] - CURVE_FIRST)] : analog_curve_i[0];
    end
    chan_in[3]         = pulse_freq_o;
    chan_zero_below[3] = 1'b0;
    chan_curve_ok[3]   = 1'b1;
    chan_curve[3]      = pulse_curve_i;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_filt_q <= '0;
    end else if (filt_tick) begin
      for (int ch = 0; ch < 4; ch++) begin
        chan_filt_q[ch] <= filt_step(chan_filt_q[ch], chan_in[ch], filter_time_i[ch]);
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_set_q <= '0;
    end else begin
      for (int ch = 0; ch < 4; ch++) begin
        chan_set_q[ch] <= chan_curve_ok[ch] ?
                          curve_map(chan_filt_q[ch], chan_curve[ch], chan_zero_below[ch]) : 16'h0000;
      end
    end
  end

  assign analog_setting_o = chan_set_q[2:0];
  assign pulse_setting_o  = chan_set_q[3];

endmodule : tci_terminal_front

`default_nettype wire

/* shared/tci_pkg.sv */
// Purpose: constants and carrier types for the terminal command and input scaling front end
// Assumes: 200 MHz core clock; analog samples arrive in millivolts or microamps
// Notes:   settings are signed, in 0.01 % steps; pulse frequencies are in 0.01 kHz steps
// What this block does
// - scheme 2: third input is run-enable, first and second give direction
// - scheme 2, enabled: forward press runs forward, reverse press runs reverse
// - both three-wire schemes stop at once when run-enable drops
// - latest action on enable, run or direction inputs sets the run state
// - scheme 3: third is enable, first is run, second is direction
// - scheme 3, enabled: run press starts; direction off forward, on reverse
// - up/down terminals change frequency at programmable rate, default 1.0 Hz/s
// - rate range follows reference resolution: fine 0.001, coarse 0.01 Hz/s steps
// - each analog curve maps min..max points linearly into +/-100 %
// - input above maximum point is treated as the maximum point
// - input below minimum point gives the per-channel below-minimum choice
// - below-minimum digit 0 gives minimum setting, digit 1 gives 0.0 %
// - current input is scaled so 1 mA equals 0.5 V
// - each analog input has a filter, 0.00 to 10.00 s, default 0.10 s
// - channels two and three have own points and filter, like channel one
// - pulse input maps 0.00..50.00 kHz linearly, with own filter and clamping
// - curve select digits pick curves for channels one to three, default 321
// - curves one to three are two-point; four and five are four-point (not built here; selecting them gives 0.0 %)
`default_nettype none

package tci_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned FILT_PERIOD_MS = 10;

  // ==========================================================================
  // digital input positions after synchronisation
  localparam int unsigned DI_ONE   = 0;
  localparam int unsigned DI_TWO   = 1;
  localparam int unsigned DI_THREE = 2;
  localparam int unsigned DI_PULSE = 3;
  localparam int unsigned DI_UP    = 4;
  localparam int unsigned DI_DOWN  = 5;
  localparam int unsigned DI_COUNT = 6;

  // ==========================================================================
  // command schemes and resolutions
  localparam logic [1:0] SCHEME_THREE_WIRE_1 = 2'h2;
  localparam logic [1:0] SCHEME_THREE_WIRE_2 = 2'h3;
  localparam logic [1:0] RES_COARSE          = 2'h1;
  localparam logic [1:0] RES_FINE            = 2'h2;
  localparam logic [15:0] RATE_MIN_STEP      = 16'h0001;
  localparam logic [15:0] RATE_MIN_DEFAULT   = 16'h000A;
  localparam logic [19:0] COARSE_TO_FINE     = 20'h0000A;
  localparam logic [15:0] RATE_RESET         = 16'h03E8;
  localparam logic signed [39:0] UHZ_PER_MHZ = 40'sh00000003E8;

  // ==========================================================================
  // scaling
  localparam logic signed [35:0] SET_LIMIT    = 36'sh000002710;
  localparam logic [15:0] PULSE_COUNT_SCALE   = 16'h000A;
  localparam logic [3:0]  CURVE_FIRST         = 4'h1;
  localparam logic [3:0]  CURVE_LAST_TWO_PT   = 4'h3;

  // ==========================================================================
  // reset values of the configuration inputs, for the integrator
  localparam logic [15:0] CURVE_MIN_IN_RESET  = 16'h0000;
  localparam logic [15:0] CURVE_MIN_SET_RESET = 16'h0000;
  localparam logic [15:0] CURVE_MAX_IN_RESET  = 16'h2710;
  localparam logic [15:0] CURVE_MAX_SET_RESET = 16'h2710;
  localparam logic [15:0] PULSE_MAX_IN_RESET  = 16'h1388;
  localparam logic [9:0]  FILTER_TIME_RESET   = 10'h00A;
  localparam logic [11:0] CURVE_SELECT_RESET  = 12'h321;
  localparam logic [2:0]  BELOW_MIN_RESET     = 3'h0;

  typedef struct packed {
    logic        [15:0] min_in;
    logic signed [15:0] min_set;
    logic        [15:0] max_in;
    logic signed [15:0] max_set;
  } tci_curve_t;

  typedef struct packed {
    logic run;
    logic reverse;
  } tci_run_t;

  typedef enum logic [1:0] {
    RUN_STOPPED,
    RUN_FORWARD,
    RUN_REVERSE
  } tci_run_state_t;

endpackage : tci_pkg

`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the terminal front end
// Assumes: tick is 20 cycles, so a filter step takes 200
// Notes:   analog and config inputs come straight from here
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tci_pkg::*;
  localparam int unsigned TCK = 20;
  logic                   core_clk_i = 1'b0;
  logic                   rst_i      = 1'b1;
  logic [4:0]             pins;
  logic                   pulse;
  logic [1:0]             scheme     = 2'h0;
  logic [1:0]             res        = 2'h2;
  logic [15:0]            rate       = 16'h03E8;
  logic [2:0][15:0]       sample     = '0;
  logic [2:0]             is_cur     = 3'h0;
  tci_curve_t [2:0]       curve;
  tci_curve_t             pcurve;
  logic [3:0][9:0]        ftime      = '0;
  logic [2:0][3:0]        sel        = {4'h3, 4'h2, 4'h1};
  logic [2:0]             below      = 3'h0;
  tci_run_t               run;
  logic signed [31:0]     offset;
  logic [2:0][15:0]       setting;
  logic [15:0]            psetting;
  logic [15:0]            pfreq;
  int                     n_fail     = 0;
  int                     n_checks   = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  tci_field_model FM (.core_clk_i, .pins_o(pins), .pulse_o(pulse));
  tci_terminal_front #(.TICK_CYC(TCK)) DUT (
    .core_clk_i, .rst_i, .digital_input_one_i(pins[0]), .digital_input_two_i(pins[1]),
    .digital_input_three_i(pins[2]), .pulse_capable_input_i(pulse), .updown_up_i(pins[3]),
    .updown_down_i(pins[4]), .terminal_command_scheme_i(scheme), .frequency_reference_resolution_i(res),
    .updown_ramp_rate_i(rate), .analog_sample_i(sample), .analog_is_current_i(is_cur),
    .analog_curve_i(curve), .pulse_curve_i(pcurve), .filter_time_i(ftime), .analog_curve_select_i(sel),
    .below_min_handling_select_i(below), .run_cmd_o(run), .updown_offset_o(offset),
    .analog_setting_o(setting), .pulse_setting_o(psetting), .pulse_freq_o(pfreq)
  );

  // ======================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int unsigned n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  task automatic key(input int unsigned idx, input logic val, input logic [1:0] exp);
    FM.set_pin(idx, val);
    cyc(8);
    check(run, exp);
  endtask : key

  // rates here except the coarse 16'hFFFF one are whole steps per tick, so their count over ten ticks is exact
  task automatic trim(input logic [1:0] r, input logic [15:0] rt, input logic u, input logic d,
                      input logic [31:0] exp);
    logic signed [31:0] a;
    res  = r;
    rate = rt;
    FM.set_pin(3, u);
    FM.set_pin(4, d);
    cyc(12);
    a = offset;
    cyc(10 * TCK);
    check(offset - a, exp);
    FM.set_pin(3, 1'b0);
    FM.set_pin(4, 1'b0);
    cyc(12);
  endtask : trim

  task automatic ana(input int unsigned ch, input logic [15:0] x, input logic [15:0] exp);
    sample[ch] = x;
    cyc(450);
    check(setting[ch], exp);
  endtask : ana

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // ======================================
  // tests
  initial begin
    curve[0] = '{16'h0000, 16'h0000, 16'h2710, 16'h2710};
    curve[1] = curve[0];
    curve[2] = '{16'h07D0, 16'hEC78, 16'h1770, 16'h1388};
    pcurve   = '{16'h0000, 16'h0000, 16'h1388, 16'h2710};
    repeat (16) @(posedge core_clk_i);
    #1;
    rst_i  = 1'b0;
    scheme = 2'h2;
    key(2, 1'b1, 2'h0);
    key(0, 1'b1, 2'h2);
    key(0, 1'b0, 2'h2);
    key(1, 1'b1, 2'h3);
    key(0, 1'b1, 2'h2);
    key(2, 1'b0, 2'h0);
    key(2, 1'b1, 2'h0);
    key(1, 1'b0, 2'h0);
    key(0, 1'b0, 2'h0);
    $display("test scheme two done");
    scheme = 2'h3;
    key(0, 1'b1, 2'h2);
    key(1, 1'b1, 2'h3);
    key(1, 1'b0, 2'h2);
    key(2, 1'b0, 2'h0);
    key(2, 1'b1, 2'h0);
    key(0, 1'b0, 2'h0);
    key(1, 1'b1, 2'h0);
    key(0, 1'b1, 2'h3);
    scheme = 2'h1;
    cyc(8);
    check(run, 2'h0);
    $display("test scheme three done");
    trim(2'h2, 16'h1388, 1'b1, 1'b0, 32'h0000_0032);
    trim(2'h1, 16'h01F4, 1'b1, 1'b0, 32'h0000_0032);
    trim(2'h2, 16'h07D0, 1'b0, 1'b1, 32'hFFFF_FFEC);
    trim(2'h2, 16'h03E8, 1'b1, 1'b1, 32'h0000_0000);
    trim(2'h1, 16'hFFFF, 1'b1, 1'b0, 32'h0000_1999);
    $display("test trim done");
    ana(0, 16'h1388, 16'h1388);
    is_cur[1] = 1'b1;
    ana(1, 16'h1F40, 16'h0FA0);
    below[2] = 1'b1;
    ana(2, 16'h03E8, 16'h0000);
    ana(2, 16'h07D0, 16'hEC78);
    below[2] = 1'b0;
    ana(2, 16'h03E8, 16'hEC78);
    ana(2, 16'h1B58, 16'h1388);
    ana(2, 16'h0BB8, 16'hF63C);
    sel[0] = 4'h3;
    ana(0, 16'h0BB8, 16'hF63C);
    sel[0] = 4'h4;
    ana(0, 16'h0BB8, 16'h0000);
    ftime[1] = 10'h3E8;
    sample[1] = 16'h3E80;
    cyc(450);
    check(setting[1] < 16'h1000, 1'b1);
    $display("test analog done");
    FM.half_cyc = 10;
    cyc(800);
    check(pfreq, 16'h0064);
    check(psetting, 16'h00C8);
    pcurve.max_in = 16'h0032;
    cyc(450);
    check(psetting, 16'h2710);
    $display("test pulse done");
    give_verdict();
  end

  // the tests take some 7000 cycles
  initial begin
    cyc(40000);
    n_fail++;
    give_verdict();
  end
endmodule : tb_top

bind tci_terminal_front tci_front_checker #(.TICK_CYC(TICK_CYC)) CHK (
  .core_clk_i, .rst_i, .digital_input_one_i, .digital_input_two_i, .digital_input_three_i,
  .updown_up_i, .updown_down_i, .terminal_command_scheme_i, .run_cmd_o, .updown_offset_o,
  .analog_setting_o, .pulse_freq_o
);

`default_nettype wire

/* tb/tci_field_model.sv */
// Purpose: switches, buttons and pulse source at the pins
// Assumes: the bench moves one pin at a time
// Notes:   pulse line rests low while the source is off
`default_nettype none

module tci_field_model (
  input  wire logic       core_clk_i,
  output logic      [4:0] pins_o,
  output logic            pulse_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned half_cyc = 0;

  initial begin
    pins_o = 5'h00;
  end

  // ======================================
  // contacts: enable stays held until the bench drops it
  task automatic set_pin(input int unsigned idx, input logic val);
    @(posedge core_clk_i);
    #1;
    pins_o[idx] = val;
  endtask : set_pin

  // ======================================
  // pulse source feeds the pulse-capable pin only
  always begin
    if (half_cyc == 0) begin
      pulse_o = 1'b0;
      @(posedge core_clk_i);
    end else begin
      repeat (half_cyc) @(posedge core_clk_i);
      #1;
      pulse_o = ~pulse_o;
    end
  end
endmodule : tci_field_model

`default_nettype wire

/* tb/tci_front_checker.sv */
// Purpose: port assertions for the terminal front end
// Assumes: pins reach run_cmd_o five edges after they move
// Notes:   config inputs held steady around presses
`default_nettype none

module tci_front_checker #(
  parameter int unsigned TICK_CYC = 20
) (
  input wire logic               core_clk_i,
  input wire logic               rst_i,
  input wire logic               digital_input_one_i,
  input wire logic               digital_input_two_i,
  input wire logic               digital_input_three_i,
  input wire logic               updown_up_i,
  input wire logic               updown_down_i,
  input wire logic [1:0]         terminal_command_scheme_i,
  input wire tci_pkg::tci_run_t  run_cmd_o,
  input wire logic signed [31:0] updown_offset_o,
  input wire logic [2:0][15:0]   analog_setting_o,
  input wire logic [15:0]        pulse_freq_o
);
  import tci_pkg::*;
  wire logic       one = digital_input_one_i;
  wire logic       two = digital_input_two_i;
  wire logic       en  = digital_input_three_i;
  wire logic [1:0] sc  = terminal_command_scheme_i;
  logic            in_rng;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ======================================
  // helper
  always_comb begin
    in_rng = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if ($signed(analog_setting_o[i]) > 16'sh2710 || $signed(analog_setting_o[i]) < -16'sh2710) begin
        in_rng = 1'b0;
      end
    end
  end

  // ======================================
  // run decode
  sequence s_press2(a, b);
    $rose(a) && $stable(b) && en && sc == 2'h2 ##1 (en && a && $stable(b) && sc == 2'h2) [*6];
  endsequence
  sequence s_press3;
    $rose(one) && $stable(two) && en && sc == 2'h3 ##1 (en && one && $stable(two) && sc == 2'h3) [*6];
  endsequence
  sequence s_drop;
    sc[1] && $fell(en) ##1 (sc[1] && !en) [*4];
  endsequence
  property p_fwd; s_press2(one, two) |-> run_cmd_o == 2'h2; endproperty
  property p_rev; s_press2(two, one) |-> run_cmd_o == 2'h3; endproperty
  property p_s3; s_press3 |-> run_cmd_o.run && run_cmd_o.reverse == two; endproperty
  property p_drop; s_drop |-> ##[1:2] run_cmd_o == 2'h0; endproperty
  property p_other; (!sc[1]) [*6] |-> run_cmd_o == 2'h0; endproperty
  a_fwd: assert property (p_fwd) else $error("forward press missed");
  a_rev: assert property (p_rev) else $error("reverse press missed");
  a_s3: assert property (p_s3) else $error("scheme 3 start wrong");
  a_drop: assert property (p_drop) else $error("no stop on enable drop");
  a_other: assert property (p_other) else $error("runs outside three-wire schemes");

  // ======================================
  // trim and scaling
  property p_hold; (updown_up_i == updown_down_i) [*8] |-> $stable(updown_offset_o); endproperty
  property p_up; (updown_up_i && !updown_down_i) [*8] |-> updown_offset_o >= $past(updown_offset_o); endproperty
  property p_clamp; in_rng; endproperty
  property p_pulse; $changed(pulse_freq_o) |-> pulse_freq_o % 16'h000A == 16'h0000; endproperty
  a_hold: assert property (p_hold) else $error("offset moved while idle");
  a_up: assert property (p_up) else $error("offset fell while trimming up");
  a_clamp: assert property (p_clamp) else $error("setting out of range");
  a_pulse: assert property (p_pulse) else $error("pulse count not scaled");
endmodule : tci_front_checker

`default_nettype wire
